// ---- tsf_pkg.sv ----
// Constants for temperature source select and fan smoothing config
package tsf_pkg;
   localparam logic [7:0] ADDR_SRC_SEL  = 8'h31;
   localparam logic [7:0] ADDR_FAN_FILT = 8'h32;
   localparam logic [7:0] ADDR_Z3_MIR   = 8'h21;
   localparam logic [7:0] ADDR_Z4_MIR   = 8'h23;
   localparam logic [7:0] ADDR_Z3_TEMP  = 8'h52;
   localparam logic [7:0] ADDR_Z4_TEMP  = 8'h53;

   localparam logic [7:0] SRC_SEL_RST   = 8'h00;
   localparam logic [7:0] FAN_FILT_RST  = 8'h00;
   localparam logic [7:0] TEMP_RST      = 8'h00;
   localparam logic [7:0] SRC_SEL_MASK  = 8'h1F;
   localparam logic [7:0] FAN_FILT_MASK = 8'h77;

   localparam int BIT_INT_ANALOG = 0;
   localparam int BIT_EXT_ANALOG = 1;
   localparam int BIT_CPU1_DIODE = 2;
   localparam int BIT_CPU2_DIODE = 3;
   localparam int BIT_INT_WR_EN  = 4;
   localparam int FAN1_LSB       = 0;
   localparam int FAN2_LSB       = 4;

   localparam logic [2:0] COEFF_BYPASS = 3'h0;

   // 95% settling times per code, in milliseconds
   localparam longint SETTLE1_MS = 98;
   localparam longint SETTLE2_MS = 237;
   localparam longint SETTLE3_MS = 510;
   localparam longint SETTLE4_MS = 1056;
   localparam longint SETTLE5_MS = 2147;
   localparam longint SETTLE6_MS = 4328;
   localparam longint SETTLE7_MS = 8689;

   localparam longint CLK_KHZ    = 250000;
   // Half-step filter needs five steps to reach 95%
   localparam longint STEPS_95   = 5;
endpackage

// ---- tsf_config.sv ----
// Zone 3/4 temperature source selection and fan drive smoothing filters
module tsf_config #(
   parameter int DUTY_W   = 9,  // Duty cycle width
   parameter int TIME_DIV = 1   // Divides step intervals for simulation
) (
   input  wire logic              clk_i,                        // Clock, 250 MHz
   input  wire logic              rst_i,                        // Async reset, high
   input  wire logic [7:0]        reg_addr_i,                   // Register address
   input  wire logic [7:0]        reg_wdata_i,                  // Write data
   input  wire logic              reg_wr_i,                     // Write strobe
   input  wire logic              reg_rd_i,                     // Read strobe
   output logic      [7:0]        reg_rdata_o,                  // Read data, next cycle
   input  wire logic [7:0]        diode_temp_i,                 // On-die diode reading
   input  wire logic              diode_vld_i,                  // Diode reading strobe
   input  wire logic [7:0]        analog_channel_eleven_value_i, // Channel 11 value
   input  wire logic              adc11_vld_i,                  // Channel 11 strobe
   input  wire logic [7:0]        analog_channel_fifteen_value_i, // Channel 15 value
   input  wire logic              adc15_vld_i,                  // Channel 15 strobe
   output logic      [7:0]        zone3_temp_o,                 // Zone 3 value
   output logic      [7:0]        zone4_temp_o,                 // Zone 4 value
   output logic                   cpu1_second_diode_enable_o,   // Pin A as diode
   output logic                   cpu2_second_diode_enable_o,   // Pin B as diode
   output logic                   analog_voltage_input_one_o,   // Pin A as analog
   output logic                   analog_voltage_input_two_o,   // Pin B as analog
   input  wire logic [DUTY_W-1:0] duty1_i,                      // Fan 1 raw duty
   input  wire logic [DUTY_W-1:0] duty2_i,                      // Fan 2 raw duty
   output logic      [DUTY_W-1:0] duty1_o,                      // Fan 1 smoothed
   output logic      [DUTY_W-1:0] duty2_o                       // Fan 2 smoothed
);

   // Interval counters are 32 bits; wider duty words are not needed
   if (DUTY_W < 2 || DUTY_W > 16 || TIME_DIV < 1) begin
      $error("tsf_config: unsupported parameters");
   end

   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);

   ////////////////////////////////////////////////////////////////////////////
   // Functions

   function automatic logic [7:0] flip_msb(input logic [7:0] v);
      flip_msb = {~v[7], v[6:0]};
   endfunction

   function automatic logic [31:0] step_cycles(input logic [2:0] code);
      longint ms;
      longint cyc;
      case (code)
         3'h1:    ms = tsf_pkg::SETTLE1_MS;
         3'h2:    ms = tsf_pkg::SETTLE2_MS;
         3'h3:    ms = tsf_pkg::SETTLE3_MS;
         3'h4:    ms = tsf_pkg::SETTLE4_MS;
         3'h5:    ms = tsf_pkg::SETTLE5_MS;
         3'h6:    ms = tsf_pkg::SETTLE6_MS;
         3'h7:    ms = tsf_pkg::SETTLE7_MS;
         default: ms = 64'h1;
      endcase
      cyc = (ms * tsf_pkg::CLK_KHZ) / (tsf_pkg::STEPS_95 * longint'(TIME_DIV));
      if (cyc < 64'h1)
         cyc = 64'h1;
      step_cycles = cyc[31:0];
   endfunction

   function automatic logic [DUTY_W-1:0] half_step(input logic [DUTY_W-1:0] y,
                                                   input logic [DUTY_W-1:0] x);
      logic signed [DUTY_W:0] d;
      logic signed [DUTY_W:0] s;
      d = $signed({1'b0, x}) - $signed({1'b0, y});
      s = $signed({1'b0, y}) + (d >>> 1);
      if (d == '0)
         half_step = y;
      else if (s == $signed({1'b0, y}))
         half_step = x;
      else
         half_step = s[DUTY_W-1:0];
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // Register decode

   logic [7:0] src_sel_r;
   logic [7:0] fan_filt_r;
   logic [7:0] zone3_r;
   logic [7:0] zone4_r;
   logic [7:0] rdata_r;

   wire wr_src  = reg_wr_i && reg_addr_i == tsf_pkg::ADDR_SRC_SEL;
   wire wr_filt = reg_wr_i && reg_addr_i == tsf_pkg::ADDR_FAN_FILT;
   wire hit_z3  = reg_addr_i == tsf_pkg::ADDR_Z3_TEMP || reg_addr_i == tsf_pkg::ADDR_Z3_MIR;
   wire hit_z4  = reg_addr_i == tsf_pkg::ADDR_Z4_TEMP || reg_addr_i == tsf_pkg::ADDR_Z4_MIR;

   wire int_analog = src_sel_r[tsf_pkg::BIT_INT_ANALOG];
   wire ext_analog = src_sel_r[tsf_pkg::BIT_EXT_ANALOG];
   wire int_wr_en  = src_sel_r[tsf_pkg::BIT_INT_WR_EN];

   wire [2:0] fan_out1_smoothing_coeff = fan_filt_r[tsf_pkg::FAN1_LSB +: 3];
   wire [2:0] fan_out2_smoothing_coeff = fan_filt_r[tsf_pkg::FAN2_LSB +: 3];

   ////////////////////////////////////////////////////////////////////////////
   // Zone value sources

   wire       z3_host = reg_wr_i && hit_z3 && int_wr_en;
   wire       z3_a11  = !int_wr_en && int_analog && adc11_vld_i;
   wire       z3_dio  = !int_wr_en && !int_analog && diode_vld_i;
   wire       z4_host = reg_wr_i && hit_z4 && !ext_analog;
   wire       z4_a15  = ext_analog && adc15_vld_i;

   wire [7:0] z3_nxt = z3_host ? reg_wdata_i :
                       z3_a11  ? flip_msb(analog_channel_eleven_value_i) :
                       z3_dio  ? diode_temp_i : zone3_r;
   wire [7:0] z4_nxt = z4_host ? reg_wdata_i :
                       z4_a15  ? flip_msb(analog_channel_fifteen_value_i) : zone4_r;

   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         src_sel_r  <= tsf_pkg::SRC_SEL_RST;
         fan_filt_r <= tsf_pkg::FAN_FILT_RST;
         zone3_r    <= tsf_pkg::TEMP_RST;
         zone4_r    <= tsf_pkg::TEMP_RST;
      end else begin
         if (wr_src)
            src_sel_r <= reg_wdata_i & tsf_pkg::SRC_SEL_MASK;
         if (wr_filt)
            fan_filt_r <= reg_wdata_i & tsf_pkg::FAN_FILT_MASK;
         zone3_r <= z3_nxt;
         zone4_r <= z4_nxt;
      end
   end

   // Consumers see the register itself, never a bypass path
   assign zone3_temp_o = zone3_r;
   assign zone4_temp_o = zone4_r;

   assign cpu1_second_diode_enable_o = src_sel_r[tsf_pkg::BIT_CPU1_DIODE];
   assign analog_voltage_input_one_o = !src_sel_r[tsf_pkg::BIT_CPU1_DIODE];
   assign cpu2_second_diode_enable_o = src_sel_r[tsf_pkg::BIT_CPU2_DIODE];
   assign analog_voltage_input_two_o = !src_sel_r[tsf_pkg::BIT_CPU2_DIODE];

   ////////////////////////////////////////////////////////////////////////////
   // Read path, one cycle after the strobe

   wire [7:0] rd_mux = (reg_addr_i == tsf_pkg::ADDR_SRC_SEL)  ? src_sel_r :
                       (reg_addr_i == tsf_pkg::ADDR_FAN_FILT) ? fan_filt_r :
                       hit_z3 ? zone3_r :
                       hit_z4 ? zone4_r : 8'h00;

   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i)
         rdata_r <= 8'h00;
      else if (reg_rd_i)
         rdata_r <= rd_mux;
   end

   assign reg_rdata_o = rdata_r;

   ////////////////////////////////////////////////////////////////////////////
   // Smoothing filters: half step toward input every interval

   logic [31:0]       cnt1_r;
   logic [31:0]       cnt2_r;
   logic [DUTY_W-1:0] y1_r;
   logic [DUTY_W-1:0] y2_r;

   wire [31:0] lim1 = step_cycles(fan_out1_smoothing_coeff);
   wire [31:0] lim2 = step_cycles(fan_out2_smoothing_coeff);
   wire        tick1 = cnt1_r >= lim1 - 32'h1;
   wire        tick2 = cnt2_r >= lim2 - 32'h1;
   wire        byp1 = fan_out1_smoothing_coeff == tsf_pkg::COEFF_BYPASS;
   wire        byp2 = fan_out2_smoothing_coeff == tsf_pkg::COEFF_BYPASS;

   wire [DUTY_W-1:0] y1_nxt = byp1 ? duty1_i : tick1 ? half_step(y1_r, duty1_i) : y1_r;
   wire [DUTY_W-1:0] y2_nxt = byp2 ? duty2_i : tick2 ? half_step(y2_r, duty2_i) : y2_r;

   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         cnt1_r <= 32'h0;
         cnt2_r <= 32'h0;
         y1_r   <= '0;
         y2_r   <= '0;
      end else begin
         cnt1_r <= (byp1 || tick1) ? 32'h0 : cnt1_r + 32'h1;
         cnt2_r <= (byp2 || tick2) ? 32'h0 : cnt2_r + 32'h1;
         y1_r   <= y1_nxt;
         y2_r   <= y2_nxt;
      end
   end

   // Coefficient change restarts the interval count at next tick, or at once when set to bypass
   assign duty1_o = y1_r;
   assign duty2_o = y2_r;

   ////////////////////////////////////////////////////////////////////////////
   // Assertions

   property p_int_analog;
      !int_wr_en && int_analog && adc11_vld_i
         |=> zone3_temp_o == {~$past(analog_channel_eleven_value_i[7]),
                              $past(analog_channel_eleven_value_i[6:0])};
   endproperty
   a_int_analog: assert property (p_int_analog) else $error("zone 3 not from channel 11");

   property p_int_diode;
      !int_wr_en && !int_analog && diode_vld_i |=> zone3_temp_o == $past(diode_temp_i);
   endproperty
   a_int_diode: assert property (p_int_diode) else $error("zone 3 not from diode");

   property p_ext_ro;
      ext_analog && !adc15_vld_i |=> $stable(zone4_temp_o);
   endproperty
   a_ext_ro: assert property (p_ext_ro) else $error("zone 4 changed while read-only");

   property p_ext_host;
      !ext_analog && reg_wr_i && hit_z4 |=> zone4_temp_o == $past(reg_wdata_i);
   endproperty
   a_ext_host: assert property (p_ext_host) else $error("zone 4 host write lost");

   property p_pin_steer;
      wr_src |=> cpu1_second_diode_enable_o == $past(reg_wdata_i[2])
                 && analog_voltage_input_two_o == !$past(reg_wdata_i[3]);
   endproperty
   a_pin_steer: assert property (p_pin_steer) else $error("pin steering wrong");

   property p_int_hold;
      int_wr_en && !(reg_wr_i && hit_z3) |=> $stable(zone3_temp_o);
   endproperty
   a_int_hold: assert property (p_int_hold) else $error("zone 3 auto update while locked");

   property p_coeff;
      wr_filt |=> fan_out1_smoothing_coeff == $past(reg_wdata_i[2:0])
                  && fan_out2_smoothing_coeff == $past(reg_wdata_i[6:4]);
   endproperty
   a_coeff: assert property (p_coeff) else $error("coefficient not stored");

   property p_bypass;
      byp2 |=> duty2_o == $past(duty2_i);
   endproperty
   a_bypass: assert property (p_bypass) else $error("bypass not transparent");

   property p_reserved;
      reg_rd_i && reg_addr_i == tsf_pkg::ADDR_FAN_FILT ##1 1'b1
         |-> reg_rdata_o[7] == 1'b0 && reg_rdata_o[3] == 1'b0;
   endproperty
   a_reserved: assert property (p_reserved) else $error("reserved bits not zero");

   property p_pin_steer2;
      wr_src |=> cpu2_second_diode_enable_o == $past(reg_wdata_i[3])
                 && analog_voltage_input_one_o == !$past(reg_wdata_i[2]);
   endproperty
   a_pin_steer2: assert property (p_pin_steer2) else $error("second pin steering wrong");

   property p_coeff_hold;
      !wr_filt |=> $stable(fan_out2_smoothing_coeff) && $stable(fan_out1_smoothing_coeff);
   endproperty
   a_coeff_hold: assert property (p_coeff_hold) else $error("coefficient changed without write");

   property p_zone3_read;
      reg_rd_i && hit_z3 |=> reg_rdata_o == $past(zone3_temp_o);
   endproperty
   a_zone3_read: assert property (p_zone3_read) else $error("zone 3 read differs from register");

   property p_zone4_read;
      reg_rd_i && hit_z4 |=> reg_rdata_o == $past(zone4_temp_o);
   endproperty
   a_zone4_read: assert property (p_zone4_read) else $error("zone 4 read differs from register");

   property p_filt_hold;
      !byp2 && !tick2 |=> $stable(duty2_o);
   endproperty
   a_filt_hold: assert property (p_filt_hold) else $error("filter moved between steps");

   property p_filt_step;
      !byp2 && tick2 && duty2_i != duty2_o |=> duty2_o != $past(duty2_o);
   endproperty
   a_filt_step: assert property (p_filt_step) else $error("filter step made no progress");

   property p_src_rsvd;
      reg_rd_i && reg_addr_i == tsf_pkg::ADDR_SRC_SEL |=> reg_rdata_o[7:5] == 3'h0;
   endproperty
   a_src_rsvd: assert property (p_src_rsvd) else $error("source reserved bits not zero");

   property p_int_host;
      int_wr_en && reg_wr_i && hit_z3 |=> zone3_temp_o == $past(reg_wdata_i);
   endproperty
   a_int_host: assert property (p_int_host) else $error("zone 3 host write lost");

   property p_ext_host_only;
      !ext_analog && !(reg_wr_i && hit_z4) |=> $stable(zone4_temp_o);
   endproperty
   a_ext_host_only: assert property (p_ext_host_only) else $error("zone 4 changed without host write");

endmodule

// ---- tsf_src_model.sv ----
// Sensor front end model: diode and analog channel samples with strobes
module tsf_src_model (
   input  wire logic       clk_i,     // Clock
   output logic      [7:0] diode_o,   // Diode reading
   output logic            diode_v_o, // Diode strobe
   output logic      [7:0] ch11_o,    // Channel 11 value
   output logic            ch11_v_o,  // Channel 11 strobe
   output logic      [7:0] ch15_o,    // Channel 15 value
   output logic            ch15_v_o   // Channel 15 strobe
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [7:0] val;
   logic [2:0] vld;
   assign diode_o   = val;
   assign ch11_o    = val;
   assign ch15_o    = val;
   assign diode_v_o = vld[0];
   assign ch11_v_o  = vld[1];
   assign ch15_v_o  = vld[2];
   initial begin
      val = 8'h00;
      vld = 3'h0;
   end
   // One-cycle sample; value scrambled after so stale data never matches
   task automatic send(input int sel, input logic [7:0] v);
      @(posedge clk_i);
      #1;
      val      = v;
      vld[sel] = 1'b1;
      @(posedge clk_i);
      #1;
      vld = 3'h0;
      val = ~v;
   endtask
endmodule

// ---- temp_source_and_fan_filter_config_tb.sv ----
// Self-checking bench for zone source select and fan smoothing config
module temp_source_and_fan_filter_config_tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic       clk_i, rst_i, wr, rd, dv, v11, v15, c1e, c2e, an1, an2;
   logic [7:0] addr, wdata, rdata, d_t, a11, a15, z3, z4;
   logic [8:0] du1, du2, dq1, dq2;
   int         miscompares = 0;
   int         n_checks = 0;
   int         cnt;
   tsf_config #(.TIME_DIV(100000)) uut (.clk_i(clk_i), .rst_i(rst_i), .reg_addr_i(addr), .reg_wdata_i(wdata),
      .reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdata), .diode_temp_i(d_t), .diode_vld_i(dv),
      .analog_channel_eleven_value_i(a11), .adc11_vld_i(v11), .analog_channel_fifteen_value_i(a15),
      .adc15_vld_i(v15), .zone3_temp_o(z3), .zone4_temp_o(z4), .cpu1_second_diode_enable_o(c1e),
      .cpu2_second_diode_enable_o(c2e), .analog_voltage_input_one_o(an1), .analog_voltage_input_two_o(an2),
      .duty1_i(du1), .duty2_i(du2), .duty1_o(dq1), .duty2_o(dq2));
   tsf_src_model src (.clk_i(clk_i), .diode_o(d_t), .diode_v_o(dv), .ch11_o(a11), .ch11_v_o(v11),
      .ch15_o(a15), .ch15_v_o(v15));
   initial begin
      clk_i = 1'b0;
      forever #2 clk_i = ~clk_i;
   end
   ////////////////////////////////////////////////////////////////////////////
   task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
      n_checks++;
      if (got !== exp) begin
         miscompares++;
         $display("MISMATCH %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk_i);
      #1;
      addr  = a;
      wdata = d;
      wr    = 1'b1;
      @(posedge clk_i);
      #1;
      wr = 1'b0;
   endtask
   task automatic rd_chk(input string what, input logic [7:0] a, input logic [7:0] exp);
      @(posedge clk_i);
      #1;
      addr = a;
      rd   = 1'b1;
      @(posedge clk_i);
      #1;
      rd = 1'b0;
      check(what, {8'h00, exp}, {8'h00, rdata});
   endtask
   task automatic conclude();
      $display("checks %0d mismatches %0d", n_checks, miscompares);
      if (miscompares == 0 && n_checks > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (100000) @(posedge clk_i);
      miscompares++;
      conclude();
   end
   initial begin
      {rst_i, wr, rd, addr, wdata, du1, du2} = {1'b1, 36'h0};
      repeat (3) @(posedge clk_i);
      #1;
      rst_i = 1'b0;
      rd_chk("src reset", tsf_pkg::ADDR_SRC_SEL, 8'h00);
      rd_chk("filt reset", tsf_pkg::ADDR_FAN_FILT, 8'h00);
      check("pin one analog", 16'h1, {15'h0, an1});
      wr_reg(tsf_pkg::ADDR_SRC_SEL, 8'hFF);
      check("pins diode", 16'h3, {14'h0, c2e, c1e});
      check("pins analog", 16'h0, {14'h0, an2, an1});
      rd_chk("src rsvd", tsf_pkg::ADDR_SRC_SEL, 8'h1F);
      wr_reg(tsf_pkg::ADDR_FAN_FILT, 8'hFF);
      rd_chk("filt rsvd", tsf_pkg::ADDR_FAN_FILT, 8'h77);
      rd_chk("unmapped", 8'h40, 8'h00);
      $display("test registers done");
      wr_reg(tsf_pkg::ADDR_SRC_SEL, 8'h00);
      src.send(0, 8'h2A);
      check("z3 diode", 16'h2A, {8'h0, z3});
      src.send(1, 8'h77);
      check("z3 ignores ch11", 16'h2A, {8'h0, z3});
      wr_reg(tsf_pkg::ADDR_Z3_TEMP, 8'h66);
      check("z3 locked", 16'h2A, {8'h0, z3});
      wr_reg(tsf_pkg::ADDR_Z4_TEMP, 8'h55);
      src.send(2, 8'h11);
      check("z4 host", 16'h55, {8'h0, z4});
      $display("test diode source done");
      wr_reg(tsf_pkg::ADDR_SRC_SEL, 8'h03);
      src.send(1, 8'h90);
      check("z3 ch11", 16'h10, {8'h0, z3});
      src.send(2, 8'h05);
      check("z4 ch15", 16'h85, {8'h0, z4});
      wr_reg(tsf_pkg::ADDR_Z4_MIR, 8'h44);
      src.send(0, 8'h3C);
      check("z4 read only", 16'h85, {8'h0, z4});
      check("z3 ignores diode", 16'h10, {8'h0, z3});
      $display("test analog source done");
      wr_reg(tsf_pkg::ADDR_SRC_SEL, 8'h13);
      wr_reg(tsf_pkg::ADDR_Z3_TEMP, 8'h33);
      src.send(1, 8'hF0);
      check("z3 host hold", 16'h33, {8'h0, z3});
      rd_chk("z3 mirror", tsf_pkg::ADDR_Z3_MIR, 8'h33);
      $display("test host write done");
      wr_reg(tsf_pkg::ADDR_FAN_FILT, 8'h10);
      du1 = 9'h155;
      du2 = 9'h100;
      @(posedge clk_i);
      @(posedge clk_i);
      #1;
      check("fan1 bypass", 16'h155, {7'h0, dq1});
      cnt = 1;
      while (dq2 !== 9'h100 && cnt < 3000) begin
         @(posedge clk_i);
         #1;
         cnt++;
      end
      check("fan2 settles", 16'h100, {7'h0, dq2});
      check("fan2 slow", 16'h1, {15'h0, cnt >= 98});
      $display("test filter done");
      conclude();
   end
endmodule
